// File: wiper_loader_defines.svh
/*
 wiper loader constants: word width, tap count and power-up code.
 assumes inclusion by the wiper loader package and module only.
*/
`ifndef WIPER_LOADER_DEFINES_SVH
`define WIPER_LOADER_DEFINES_SVH
`define WL_CODE_W 8
`define WL_TAP_COUNT 256
`define WL_MIDSCALE 8'h80
`define WL_BITCNT_W 4
`endif

// File: wiper_loader_pkg.sv
/*
 wiper loader types: the serial link pins and the wiper code word.
 assumes the defines header is on the include path.
*/
`include "wiper_loader_defines.svh"
package wiper_loader_pkg;
   // select and data pins of the three-wire link as seen by the device
   typedef struct packed {
      logic select;
      logic serial_data_input;
   } link_pins_s;
   typedef logic [`WL_CODE_W-1:0] code_t;
endpackage : wiper_loader_pkg

// File: three_wire_wiper_loader.sv
/*
 three-wire write-only loader for a 256-step wiper code latch.
 link logic runs on the serial clock; select and a gray edge count
 cross into clk_i by two flip-flops each; the word is read at commit.
 assumes the serial clock is stopped outside frames and during reset.
*/
// Notes on behaviour
// - each transfer is eight bits, most significant bit first
// - while select is high, data shifts in on each rising serial edge
// - select falling copies the shift register into the wiper code latch
// - with more than eight edges only the last eight bits are kept
// - the wiper code latch holds midscale after reset, before writes
// - the latched code picks one of 256 taps, zero at the b end
// - select is active high; the link idles with select low
`timescale 1ns/1ps
`include "wiper_loader_defines.svh"
module three_wire_wiper_loader
   import wiper_loader_pkg::*;
#(
   parameter int CODE_W = `WL_CODE_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic serial_clk_i,
   input wire logic select_i,
   input wire logic serial_data_input_i,
   output logic [CODE_W-1:0] wiper_code_latch_o,
   output logic [`WL_TAP_COUNT-1:0] tap_select_o,
   output logic load_done_o
);
   // ==========================================================
   // link domain: shift register
   // ==========================================================
   link_pins_s pins;
   logic [CODE_W-1:0] shift_reg;
   logic [CODE_W-1:0] shift_next;
   assign pins.select = select_i;
   assign pins.serial_data_input = serial_data_input_i;

   always_comb begin
      shift_next = shift_reg;
      if (pins.select) begin
         // msb first, oldest bits fall out the top
         shift_next = {shift_reg[CODE_W-2:0],
            pins.serial_data_input};
      end
   end

   // rising edges only; cleared asynchronously by rst_i
   always_ff @(posedge serial_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_reg <= '0;
      end else begin
         shift_reg <= shift_next;
      end
   end

   // ==========================================================
   // link domain: gray count of accepted serial edges
   // ==========================================================
   // one bit moves per edge, so clk_i may sample it at any time
   logic [`WL_BITCNT_W-1:0] edge_gray_reg;
   logic [`WL_BITCNT_W-1:0] edge_gray_next;

   // binary to gray
   function automatic logic [`WL_BITCNT_W-1:0] to_gray(
      input logic [`WL_BITCNT_W-1:0] b
   );
      return b ^ (b >> 1);
   endfunction : to_gray

   // gray back to binary
   function automatic logic [`WL_BITCNT_W-1:0] from_gray(
      input logic [`WL_BITCNT_W-1:0] g
   );
      logic [`WL_BITCNT_W-1:0] b;
      b = g;
      for (int i = `WL_BITCNT_W - 2; i >= 0; i--) begin
         b[i] = b[i + 1] ^ g[i];
      end
      return b;
   endfunction : from_gray

   always_comb begin
      edge_gray_next = edge_gray_reg;
      if (pins.select) begin
         edge_gray_next =
            to_gray(from_gray(edge_gray_reg) + `WL_BITCNT_W'(1));
      end
   end

   always_ff @(posedge serial_clk_i or posedge rst_i) begin
      if (rst_i) begin
         edge_gray_reg <= '0;
      end else begin
         edge_gray_reg <= edge_gray_next;
      end
   end

   // ==========================================================
   // checks: link domain
   // ==========================================================
   a_shift_msb: assert property (@(posedge serial_clk_i)
      disable iff (rst_i)
      select_i |=> shift_reg[0] == $past(serial_data_input_i)
         && shift_reg[CODE_W-1:1] == $past(shift_reg[CODE_W-2:0]))
      else $error("shift order wrong");

   a_shift_idle: assert property (@(posedge serial_clk_i)
      disable iff (rst_i)
      !select_i |=> $stable(shift_reg))
      else $error("shift while deselected");

   a_edge_step: assert property (@(posedge serial_clk_i)
      disable iff (rst_i)
      select_i |=> from_gray(edge_gray_reg)
         == from_gray($past(edge_gray_reg)) + `WL_BITCNT_W'(1))
      else $error("edge count did not step");

   a_edge_idle: assert property (@(posedge serial_clk_i)
      disable iff (rst_i)
      !select_i |=> $stable(edge_gray_reg))
      else $error("edge counted while deselected");

   // ==========================================================
   // system domain: synchronisers and commit
   // ==========================================================
   logic sel_meta_reg;
   logic sel_meta_next;
   logic sel_sync_reg;
   logic sel_sync_next;
   logic sel_prev_reg;
   logic sel_prev_next;
   logic [`WL_BITCNT_W-1:0] edge_meta_reg;
   logic [`WL_BITCNT_W-1:0] edge_meta_next;
   logic [`WL_BITCNT_W-1:0] edge_sync_reg;
   logic [`WL_BITCNT_W-1:0] edge_sync_next;
   logic [CODE_W-1:0] code_reg;
   logic [CODE_W-1:0] code_next;
   logic done_reg;
   logic done_next;
   logic commit;

   // shift_reg is stable once select is low: serial edges then do not shift it
   assign commit = sel_prev_reg & ~sel_sync_reg;

   // two flip-flops per crossing; only the second reads the first
   always_comb begin
      sel_meta_next = select_i;
      sel_sync_next = sel_meta_reg;
      sel_prev_next = sel_sync_reg;
      edge_meta_next = edge_gray_reg;
      edge_sync_next = edge_meta_reg;
      code_next = code_reg;
      done_next = 1'b0;
      if (commit) begin
         code_next = shift_reg;
         done_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_meta_reg <= 1'b0;
         sel_sync_reg <= 1'b0;
         sel_prev_reg <= 1'b0;
         edge_meta_reg <= '0;
         edge_sync_reg <= '0;
         code_reg <= `WL_MIDSCALE;
         done_reg <= 1'b0;
      end else begin
         sel_meta_reg <= sel_meta_next;
         sel_sync_reg <= sel_sync_next;
         sel_prev_reg <= sel_prev_next;
         edge_meta_reg <= edge_meta_next;
         edge_sync_reg <= edge_sync_next;
         code_reg <= code_next;
         done_reg <= done_next;
      end
   end

   // ==========================================================
   // checks: system domain
   // ==========================================================
   a_meta_chain: assert property (@(posedge clk_i)
      disable iff (rst_i)
      sel_sync_reg == $past(sel_meta_reg))
      else $error("select synchroniser skipped a stage");

   a_prev_chain: assert property (@(posedge clk_i)
      disable iff (rst_i)
      sel_prev_reg == $past(sel_sync_reg))
      else $error("select edge stage skipped");

   a_commit_loads: assert property (@(posedge clk_i)
      disable iff (rst_i)
      commit |=> (code_reg == $past(shift_reg) && done_reg))
      else $error("code not loaded on select fall");

   a_code_holds: assert property (@(posedge clk_i)
      disable iff (rst_i)
      !commit |=> $stable(code_reg))
      else $error("code changed without commit");

   a_reset_mid: assert property (@(posedge clk_i)
      rst_i |=> code_reg == `WL_MIDSCALE)
      else $error("code not midscale after reset");

   a_commit_late: assert property (@(posedge clk_i)
      disable iff (rst_i)
      $fell(sel_sync_reg) |-> commit)
      else $error("commit missed the synchronised select fall");

   a_done_cause: assert property (@(posedge clk_i)
      disable iff (rst_i)
      done_reg |-> $past(commit))
      else $error("load_done without a commit");

   a_done_pulse: assert property (@(posedge clk_i)
      disable iff (rst_i)
      done_reg |=> !done_reg)
      else $error("load_done longer than one cycle");

   a_late_edge: assert property (@(posedge clk_i)
      disable iff (rst_i)
      commit |-> $stable(edge_sync_reg))
      else $error("serial edge seen after select fell");

   a_edge_gray: assert property (@(posedge clk_i)
      disable iff (rst_i)
      $onehot0(edge_sync_reg ^ $past(edge_sync_reg)))
      else $error("edge count moved by more than one step");

   a_done_reset: assert property (@(posedge clk_i)
      rst_i |=> !done_reg)
      else $error("load_done high after reset");

   a_sel_reset: assert property (@(posedge clk_i)
      rst_i |=> !sel_sync_reg && !sel_prev_reg)
      else $error("select stages not idle after reset");

   a_frame_quiet: assert property (@(posedge clk_i)
      disable iff (rst_i)
      sel_sync_reg |-> !done_reg)
      else $error("load_done inside a frame");

   // ==========================================================
   // tap decode
   // ==========================================================
   // one-hot tap select, registered together with the code
   logic [`WL_TAP_COUNT-1:0] tap_reg;
   logic [`WL_TAP_COUNT-1:0] tap_next;
   genvar g;
   generate
      for (g = 0; g < `WL_TAP_COUNT; g++) begin : g_tap
         assign tap_next[g] = (code_next == CODE_W'(g));
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tap_reg <= '0;
         tap_reg[`WL_MIDSCALE] <= 1'b1;
      end else begin
         tap_reg <= tap_next;
      end
   end

   // outputs straight from flip-flops
   assign wiper_code_latch_o = code_reg;
   assign tap_select_o = tap_reg;
   assign load_done_o = done_reg;

   // ==========================================================
   // checks: tap decode
   // ==========================================================
   a_tap_onehot: assert property (@(posedge clk_i)
      disable iff (rst_i)
      tap_reg[code_reg] && $onehot(tap_reg))
      else $error("tap does not match code");

   a_tap_reset: assert property (@(posedge clk_i)
      rst_i |=> tap_reg[`WL_MIDSCALE] && $onehot(tap_reg))
      else $error("tap not midscale after reset");

   a_tap_follow: assert property (@(posedge clk_i)
      disable iff (rst_i)
      $changed(code_reg) |-> $changed(tap_reg))
      else $error("tap did not follow the code");

   a_tap_b_end: assert property (@(posedge clk_i)
      disable iff (rst_i)
      code_reg == '0 |-> tap_reg[0])
      else $error("code zero not at the b end");

   a_tap_top: assert property (@(posedge clk_i)
      disable iff (rst_i)
      code_reg == '1 |-> tap_reg[`WL_TAP_COUNT-1])
      else $error("full code not at the top tap");

endmodule : three_wire_wiper_loader

// File: host_link_model.sv
/* host model: select, serial clock and data, msb first.
 assumes frames are spaced by the caller. */
`timescale 1ns/1ps
module host_link_model (
   output logic sclk_o,
   output logic sel_o,
   output logic data_o
);
   initial begin
      sclk_o = 1'b0;
      sel_o = 1'b0;
      data_o = 1'b0;
   end
   // ========
   // frame of n bits, clock only inside
   task send(input logic [15:0] w, input int n);
      sel_o = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         data_o = w[i];
         #16 sclk_o = 1'b1;
         #16 sclk_o = 1'b0;
      end
      data_o = ~data_o;
      #16 sel_o = 1'b0;
   endtask : send
   // ========
   // clean edges with select low, to be ignored
   task idle_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         data_o = ~data_o;
         #16 sclk_o = 1'b1;
         #16 sclk_o = 1'b0;
      end
   endtask : idle_clocks
endmodule : host_link_model

// File: testbench.sv
/* bench: frames through the host model, results checked from a queue.
 assumes commit within a few clk_i cycles of select falling. */
`timescale 1ns/1ps
module testbench;
   import wiper_loader_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic sclk, sel, ser_data, done;
   code_t code, w;
   logic [255:0] tap;
   code_t exp_q[$];
   int n_mismatch = 0;
   int n_compared = 0;
   logic [31:0] rng = 32'h000098bf;
   always #2.5 clk_i = ~clk_i;
   host_link_model host_i (.sclk_o(sclk), .sel_o(sel), .data_o(ser_data));
   three_wire_wiper_loader three_wire_wiper_loader_i (.clk_i(clk_i),
      .rst_i(rst_i), .serial_clk_i(sclk), .select_i(sel),
      .serial_data_input_i(ser_data), .wiper_code_latch_o(code),
      .tap_select_o(tap), .load_done_o(done));
   // ========
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic check(input logic [255:0] seen, input logic [255:0] want);
      n_compared++;
      if (seen !== want) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic frame(input logic [15:0] v, input int n);
      exp_q.push_back(v[7:0]);
      host_i.send(v, n);
      repeat (12) @(posedge clk_i);
   endtask : frame
   task complete_run;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run
   // ========
   // monitor
   always @(negedge clk_i) begin
      if (done === 1'b1) begin
         w = exp_q.pop_front();
         check(code, w);
         check(tap, 256'h1 << w);
      end
   end
   // ========
   // main sequence and watchdog
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      check(code, 8'h80);
      check(tap, 256'h1 << 128);
      $display("reset test done");
      for (int i = 0; i < 20; i++) begin
         rng = xs(rng);
         frame(rng[15:0], 8);
      end
      frame(16'h00ff, 8);
      frame(16'h0000, 8);
      $display("random test done");
      frame(16'hf35a, 12);
      $display("long frame test done");
      host_i.idle_clocks(4);
      exp_q.push_back(8'h5a);
      host_i.send(16'h0000, 0);
      repeat (12) @(posedge clk_i);
      check(exp_q.size(), 0);
      $display("deselected clock test done");
      complete_run();
   end
   initial begin
      #30000;
      n_mismatch++;
      complete_run();
   end
endmodule : testbench
